// ### pkg/scbl_pkg.sv
// Purpose: Shared constants and types for the special command block loader.
// Assumes: Blocks are arrays of signed 16-bit words moved one word per cycle.
// Notes:   Both ends and the test bench use these names.
package scbl_pkg;
   // Block geometry.
   localparam int          WORD_W        = 16;
   localparam int          BLK_WORDS     = 248;
   localparam int          REC_WORDS     = 6;
   localparam int          REC_BASE      = 2;
   localparam int          IDX_BASE      = 2;
   localparam int          MAX_REC       = 10;
   localparam int          MAX_IDX       = 60;
   localparam int          CNT_WORD      = 1;
   localparam int          ID_WORD       = 0;
   // Block identifiers.
   localparam logic [15:0] ID_SPECIAL    = 16'h26ac;  // 9900.
   localparam logic [15:0] ID_USER_CMD   = 16'h26ad;  // 9901.
   localparam logic [15:0] ID_CMD_CTRL   = 16'h26ae;  // 9902.
   // Record field positions.
   localparam int          F_DB          = 0;
   localparam int          F_SESS        = 1;
   localparam int          F_SECT        = 2;
   localparam int          F_TYPE        = 3;
   localparam int          F_ADDR        = 4;
   localparam int          F_QUAL        = 5;
   // Configured command list.
   localparam int          LIST_DEPTH    = 64;
   localparam logic [1:0]  EN_ON_CHANGE  = 2'h2;
   // Step and pulse actions.
   localparam logic [15:0] VAL_MINUS_ONE = 16'hffff;
   localparam logic [15:0] VAL_ONE       = 16'h0001;
   localparam logic [15:0] VAL_ZERO      = 16'h0000;

   typedef enum logic [2:0] {
      SCBL_ACT_NONE  = 3'h0,
      SCBL_ACT_LOWER = 3'h1,
      SCBL_ACT_HIGHER= 3'h2,
      SCBL_ACT_P_OFF = 3'h3,
      SCBL_ACT_P_ON  = 3'h4
   } scbl_act_t;

   typedef struct packed {
      logic [15:0] db;
      logic [15:0] sess;
      logic [15:0] sect;
      logic [15:0] typ;
      logic [15:0] addr;
      logic [15:0] qual;
   } scbl_rec_t;
endpackage : scbl_pkg

// ### pkg/scbl_if.sv
// Purpose: Carrier between the controller end and the module end.
// Assumes: One word per cycle, controller drives block words in order 0 up.
// Notes:   No clocking block; the bench joins both ends here.
`timescale 1ns/1ns
interface scbl_if (input wire logic clk, input wire logic rst);
   logic        wr_valid;   // Word of the written block is present.
   logic [7:0]  wr_idx;     // Word index within the block.
   logic [15:0] wr_data;    // Word value.
   logic        wr_last;    // Last word of the block.
   logic        busy;       // Module still loading a block.
   logic [15:0] next_id;    // Word one of the returned block.
   modport host   (input clk, rst, busy, next_id, output wr_valid, wr_idx, wr_data, wr_last);
   modport module_end (input clk, rst, wr_valid, wr_idx, wr_data, wr_last, output busy, next_id);
endinterface : scbl_if

// ### rtl/scbl_host.sv
// Purpose: Controller end that writes special blocks word by word.
// Assumes: User holds the block image; block start requested by a pulse.
// Notes:   Waits for the module to be idle before a new block.
`timescale 1ns/1ns
module scbl_host (
   // Clock and reset.
   input  wire logic              REF_CLK_IN,
   input  wire logic              SYS_RST_IN,
   // User side.
   input  wire logic              SEND_IN,
   input  wire logic [15:0]       IMG_IN [0:scbl_pkg::BLK_WORDS-1],
   output logic                   DONE_OUT,
   output logic [15:0]            NEXT_ID_OUT,
   // Link.
   scbl_if.host                   link
);
   logic       act_reg, act_next;
   logic [7:0] idx_reg, idx_next;
   logic       done_reg, done_next;
   logic       v_reg, v_next;
   logic [15:0] d_reg, d_next;
   logic       l_reg, l_next;
   logic [7:0] o_reg, o_next;
   logic [15:0] id_reg, id_next;

   // Walks the image; count words 1..10 or 1..60 are the user's care.
   // count field check is caller side.
   always_comb
   begin
      act_next  = act_reg;
      idx_next  = idx_reg;
      done_next = 1'b0;
      v_next    = 1'b0;
      d_next    = d_reg;
      l_next    = 1'b0;
      o_next    = o_reg;
      id_next   = link.next_id;
      if (!act_reg && SEND_IN && !link.busy)
      begin
         act_next = 1'b1;
         idx_next = 8'h00;
      end
      else if (act_reg)
      begin
         v_next = 1'b1;
         o_next = idx_reg;
         d_next = IMG_IN[idx_reg];
         // whole block sent, spares through 247 included.
         l_next = (idx_reg == 8'(scbl_pkg::BLK_WORDS - 1));
         idx_next = idx_reg + 8'h01;
         if (l_next)
         begin
            act_next  = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   // Registers the sender state.
   always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         act_reg  <= 1'b0;
         idx_reg  <= 8'h00;
         done_reg <= 1'b0;
         v_reg    <= 1'b0;
         d_reg    <= 16'h0000;
         l_reg    <= 1'b0;
         o_reg    <= 8'h00;
         id_reg   <= 16'h0000;
      end
      else
      begin
         act_reg  <= act_next;
         idx_reg  <= idx_next;
         done_reg <= done_next;
         v_reg    <= v_next;
         d_reg    <= d_next;
         l_reg    <= l_next;
         o_reg    <= o_next;
         id_reg   <= id_next;
      end
   end

   assign link.wr_valid = v_reg;
   assign link.wr_idx   = o_reg;
   assign link.wr_data  = d_reg;
   assign link.wr_last  = l_reg;
   assign DONE_OUT      = done_reg;
   assign NEXT_ID_OUT   = id_reg;
endmodule : scbl_host

// ### rtl/scbl_loader.sv
// Purpose: Module end that interprets special blocks and fills the queue.
// Assumes: Configured command list is loaded through the config port.
// Notes:   No response block is built; queue entries leave at high priority.
//
// Overview of operation
// - IDs above 9900 are special requests.
// - Block 9901 queues all its records.
// - 9901 count valid one through ten.
// - Records are six-word slots from word two.
// - Record fields db, session, sector, type, address, qualifier.
// - No response; queued commands get high priority.
// - 9902 queues commands regardless of enable bit.
// - 9902 count valid one through sixty.
// - Words two to sixty-one are zero-based indices.
// - Skip commands whose unit is undefined.
// - No response; cyclic list resumes afterwards.
// - Step value minus one lower, one higher.
// - Enable code two fires on point change.
// - Controller prefers 9901 for pulse outputs.
// - Returned word one names next expected block.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
module scbl_loader (
   // Clock and reset.
   input  wire logic              REF_CLK_IN,
   input  wire logic              SYS_RST_IN,
   // Link.
   scbl_if.module_end             link,
   // Configured list load.
   input  wire logic              CFG_WE_IN,
   input  wire logic [5:0]        CFG_IDX_IN,
   input  wire scbl_pkg::scbl_rec_t CFG_REC_IN,
   input  wire logic              CFG_UNIT_OK_IN,
   input  wire logic [1:0]        CFG_EN_IN,
   // Database point changes for the cyclic list.
   input  wire logic              DB_CHG_IN,
   input  wire logic [15:0]       DB_IDX_IN,
   input  wire logic [15:0]       DB_VAL_IN,
   // Normal next block id.
   input  wire logic [15:0]       NORM_ID_IN,
   // Command engine side.
   input  wire logic              CMD_READY_IN,
   output logic                   CMD_VALID_OUT,
   output logic                   CMD_HIPRI_OUT,
   output scbl_pkg::scbl_rec_t    CMD_REC_OUT,
   output scbl_pkg::scbl_act_t    CMD_ACT_OUT,
   output logic                   DROP_OUT
);
   typedef enum logic [1:0] {SCBL_IDLE = 2'b00, SCBL_RECV = 2'b01, SCBL_ISSUE = 2'b11} scbl_st_t;

   // Block image and configured list.
   logic [15:0]          img   [0:61];
   scbl_pkg::scbl_rec_t  list  [0:scbl_pkg::LIST_DEPTH-1];
   logic                 unit_ok [0:scbl_pkg::LIST_DEPTH-1];
   logic [1:0]           en_code [0:scbl_pkg::LIST_DEPTH-1];

   scbl_st_t             st_reg, st_next;
   logic [15:0]          id_reg, id_next;
   logic [5:0]           pos_reg, pos_next;
   logic                 v_reg, v_next;
   logic                 hi_reg, hi_next;
   scbl_pkg::scbl_rec_t  rec_reg, rec_next;
   scbl_pkg::scbl_act_t  act_reg, act_next;
   logic                 drop_reg, drop_next;
   logic [15:0]          nid_reg, nid_next;

   // Maps a record's value to a step or pulse action.
   function automatic scbl_pkg::scbl_act_t act_of(input logic [15:0] v, input logic [15:0] typ);
      act_of = scbl_pkg::SCBL_ACT_NONE;
      if (typ[0] && v == scbl_pkg::VAL_MINUS_ONE)
         act_of = scbl_pkg::SCBL_ACT_LOWER;
      else if (typ[0] && v == scbl_pkg::VAL_ONE)
         act_of = scbl_pkg::SCBL_ACT_HIGHER;
      else if (!typ[0] && v == scbl_pkg::VAL_ZERO)
         act_of = scbl_pkg::SCBL_ACT_P_OFF;
      else if (!typ[0] && v == scbl_pkg::VAL_ONE)
         act_of = scbl_pkg::SCBL_ACT_P_ON;
   endfunction : act_of

   // Captures words of interest and loads the configured list.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (link.wr_valid && link.wr_idx < 8'h3e)
         img[link.wr_idx[5:0]] <= link.wr_data;
      if (CFG_WE_IN)
      begin
         list[CFG_IDX_IN]    <= CFG_REC_IN;
         unit_ok[CFG_IDX_IN] <= CFG_UNIT_OK_IN;
         en_code[CFG_IDX_IN] <= CFG_EN_IN;
      end
   end

   // Block decode and issue sequencing.
   always_comb
   begin
      logic [15:0] cnt;
      logic [5:0]  li;
      scbl_pkg::scbl_rec_t r;
      cnt       = img[scbl_pkg::CNT_WORD];
      li        = img[6'(scbl_pkg::IDX_BASE) + pos_reg][5:0];
      r         = '0;
      st_next   = st_reg;
      id_next   = id_reg;
      pos_next  = pos_reg;
      v_next    = v_reg && !CMD_READY_IN;
      hi_next   = hi_reg;
      rec_next  = rec_reg;
      act_next  = act_reg;
      drop_next = 1'b0;
      // word one names next expected block.
      nid_next  = (st_reg == SCBL_IDLE) ? NORM_ID_IN : nid_reg;
      unique case (st_reg)
         SCBL_IDLE:
            if (link.wr_valid && link.wr_idx == 8'(scbl_pkg::ID_WORD))
            begin
               id_next = link.wr_data;
               // special block test.
               // Words are signed, so the null block -1 must not count as special.
               if ($signed(link.wr_data) > $signed(scbl_pkg::ID_SPECIAL))
                  st_next = SCBL_RECV;
            end
         SCBL_RECV:
            if (link.wr_valid && link.wr_last)
            begin
               st_next  = SCBL_ISSUE;
               pos_next = 6'h00;
            end
         SCBL_ISSUE:
            if (!v_reg || CMD_READY_IN)
            begin
               if ((id_reg == scbl_pkg::ID_USER_CMD && (cnt < 16'h0001 || cnt > 16'(scbl_pkg::MAX_REC))) ||
                   (id_reg == scbl_pkg::ID_CMD_CTRL && (cnt < 16'h0001 || cnt > 16'(scbl_pkg::MAX_IDX))) ||
                   (id_reg != scbl_pkg::ID_USER_CMD && id_reg != scbl_pkg::ID_CMD_CTRL))
               begin
                  drop_next = 1'b1;
                  st_next   = SCBL_IDLE;
               end
               else if (16'(pos_reg) >= cnt)
                  st_next = SCBL_IDLE;
               else if (id_reg == scbl_pkg::ID_USER_CMD)
               begin
                  r.db   = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_DB)];
                  r.sess = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_SESS)];
                  r.sect = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_SECT)];
                  r.typ  = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_TYPE)];
                  r.addr = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_ADDR)];
                  r.qual = img[6'(scbl_pkg::REC_BASE) + pos_reg * 6'(scbl_pkg::REC_WORDS) + 6'(scbl_pkg::F_QUAL)];
                  rec_next = r;
                  act_next = act_of(r.qual, r.typ);
                  v_next   = 1'b1;
                  hi_next  = 1'b1;
                  pos_next = pos_reg + 6'h01;
               end
               else
               begin
                  rec_next = list[li];
                  act_next = act_of(list[li].qual, list[li].typ);
                  v_next   = unit_ok[li];
                  hi_next  = 1'b1;
                  pos_next = pos_reg + 6'h01;
               end
            end
         default:
            st_next = SCBL_IDLE;
      endcase
      if (st_reg == SCBL_IDLE && !v_reg && DB_CHG_IN && en_code[DB_IDX_IN[5:0]] == scbl_pkg::EN_ON_CHANGE &&
          unit_ok[DB_IDX_IN[5:0]])
      begin
         rec_next = list[DB_IDX_IN[5:0]];
         act_next = act_of(DB_VAL_IN, list[DB_IDX_IN[5:0]].typ);
         v_next   = 1'b1;
         hi_next  = 1'b0;
      end
   end

   // Registers the decoder state.
   always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         st_reg   <= SCBL_IDLE;
         id_reg   <= 16'h0000;
         pos_reg  <= 6'h00;
         v_reg    <= 1'b0;
         hi_reg   <= 1'b0;
         rec_reg  <= '0;
         act_reg  <= scbl_pkg::SCBL_ACT_NONE;
         drop_reg <= 1'b0;
         nid_reg  <= 16'h0000;
      end
      else
      begin
         st_reg   <= st_next;
         id_reg   <= id_next;
         pos_reg  <= pos_next;
         v_reg    <= v_next;
         hi_reg   <= hi_next;
         rec_reg  <= rec_next;
         act_reg  <= act_next;
         drop_reg <= drop_next;
         nid_reg  <= nid_next;
      end
   end

   assign CMD_VALID_OUT = v_reg;
   assign CMD_HIPRI_OUT = hi_reg;
   assign CMD_REC_OUT   = rec_reg;
   assign CMD_ACT_OUT   = act_reg;
   assign DROP_OUT      = drop_reg;
   assign link.busy     = (st_reg != SCBL_IDLE);
   assign link.next_id  = nid_reg;
endmodule : scbl_loader

// ### sim/scbl_assertions.sv
// Purpose: Checks word framing and pacing on the special block link.
// Assumes: One clock; reset is active high and asynchronous.
// Notes:   Sees the carrier signals only.
`timescale 1ns/1ns
module scbl_assertions (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst,
   // Link.
   input wire logic        wr_valid,
   input wire logic [7:0]  wr_idx,
   input wire logic        wr_last,
   input wire logic        busy
);
   // All checks share the link clock and reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Blocks start at word zero.
   idx_start_a: assert property ($rose(wr_valid) |-> wr_idx == 8'h00)
      else $error("block did not start at word zero");
   // Words follow without gaps, one index up each cycle.
   idx_step_a: assert property (wr_valid && !wr_last |=> wr_valid && wr_idx == $past(wr_idx) + 8'h01)
      else $error("word index did not advance by one");
   // The last word is word 247.
   last_word_a: assert property (wr_last |-> wr_valid && wr_idx == 8'hf7)
      else $error("last word flagged at wrong index");
   // The word after the last one is empty.
   end_gap_a: assert property (wr_last |=> !wr_valid)
      else $error("word sent after last word");
   // No index beyond the block.
   idx_range_a: assert property (wr_valid |-> wr_idx <= 8'hf7)
      else $error("word index beyond block");
   // A block only starts after the loader is idle.
   order_busy_a: assert property ($rose(wr_valid) |-> !$past(busy))
      else $error("block started while loader busy");
   // Link is quiet at the release of reset.
   rst_quiet_a: assert property ($fell(rst) |-> !wr_valid && !busy)
      else $error("link active at reset release");
   // Loader frees itself after a block within a bounded time.
   busy_free_a: assert property (wr_last |-> ##[1:600] !busy)
      else $error("loader stayed busy after block");

   // Main scenarios seen.
   blk_end_c: cover property (wr_last);
   blk_start_c: cover property ($rose(wr_valid));
   busy_fall_c: cover property ($fell(busy));
endmodule : scbl_assertions

// ### sim/special_command_block_loader_test.sv
// Purpose: Drives host and loader ends joined by the carrier.
// Assumes: Engine ready stalls one cycle in four.
// Notes:   Commands leaving the loader are queued by a monitor.
`timescale 1ns/1ns
module special_command_block_loader_test;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                send = 1'b0;
   logic [15:0]         img [0:scbl_pkg::BLK_WORDS-1];
   logic                done, cvalid, hipri, drop, ready = 1'b0, cfg_we = 1'b0, cfg_ok = 1'b0, db_chg = 1'b0;
   logic [15:0]         nid, db_idx = 16'h0000, db_val = 16'h0000, norm_id = 16'h0003;
   logic [5:0]          cfg_idx = 6'h00;
   logic [1:0]          cfg_en = 2'h0;
   logic [1:0]          cyc = 2'h0;
   scbl_pkg::scbl_rec_t crec, cfg_rec = '0;
   scbl_pkg::scbl_act_t cact;
   scbl_pkg::scbl_rec_t q_rec [$];
   logic                q_hp [$];
   scbl_pkg::scbl_act_t q_act [$];
   int                  mismatches = 0, total_checks = 0, drops = 0;

   // Clock and stalling engine.
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 2'h1;
      ready <= (cyc != 2'h3);
   end

   scbl_if link (.clk(clk), .rst(rst));
   scbl_host scbl_host_i (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .SEND_IN(send), .IMG_IN(img), .DONE_OUT(done),
      .NEXT_ID_OUT(nid), .link(link));
   scbl_loader scbl_loader_i (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .link(link), .CFG_WE_IN(cfg_we),
      .CFG_IDX_IN(cfg_idx), .CFG_REC_IN(cfg_rec), .CFG_UNIT_OK_IN(cfg_ok), .CFG_EN_IN(cfg_en),
      .DB_CHG_IN(db_chg), .DB_IDX_IN(db_idx), .DB_VAL_IN(db_val), .NORM_ID_IN(norm_id),
      .CMD_READY_IN(ready), .CMD_VALID_OUT(cvalid), .CMD_HIPRI_OUT(hipri), .CMD_REC_OUT(crec),
      .CMD_ACT_OUT(cact), .DROP_OUT(drop));
   scbl_assertions scbl_assertions_i (.clk(clk), .rst(rst), .wr_valid(link.wr_valid), .wr_idx(link.wr_idx),
      .wr_last(link.wr_last), .busy(link.busy));

   // Monitor collects accepted commands and discards.
   always @(posedge clk)
   begin
      if (cvalid === 1'b1 && ready === 1'b1)
      begin
         q_rec.push_back(crec);
         q_hp.push_back(hipri);
         q_act.push_back(cact);
      end
      if (drop === 1'b1)
         drops++;
   end

   function automatic scbl_pkg::scbl_rec_t mk(input logic [7:0] n);
      return {8'h10, n, 8'h20, n, 8'h30, n, 8'h40, n, 8'h50, n, 8'h60, n};
   endfunction : mk

   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Sends one block and waits until the loader has drained it.
   task automatic send_blk(input logic [15:0] id, input logic [15:0] cnt);
      int k;
      img[0] <= id;
      img[1] <= cnt;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 600)
      begin
         @(negedge clk);
         k++;
      end
      while ((link.busy !== 1'b0 || cvalid !== 1'b0) && k < 1200)
      begin
         @(negedge clk);
         k++;
      end
      chk(k < 1200, 1'b1);
      repeat (4) @(posedge clk);
   endtask : send_blk

   task automatic pop(input scbl_pkg::scbl_rec_t r, input logic hp);
      chk(q_rec.size() > 0, 1'b1);
      if (q_rec.size() > 0)
      begin
         chk(q_rec.pop_front(), r);
         chk(q_hp.pop_front(), hp);
         void'(q_act.pop_front());
      end
   endtask : pop

   task automatic cfg(input logic [5:0] i, input scbl_pkg::scbl_rec_t r, input logic ok, input logic [1:0] en);
      {cfg_we, cfg_idx, cfg_rec, cfg_ok, cfg_en} <= {1'b1, i, r, ok, en};
      @(posedge clk);
      cfg_we <= 1'b0;
      // One idle edge keeps a following call from rewriting the strobe in this step.
      @(posedge clk);
   endtask : cfg

   // Ten records, the largest count, queued in order at high priority.
   task automatic sc_user();
      for (int n = 0; n < 10; n++)
         {img[2+6*n], img[3+6*n], img[4+6*n], img[5+6*n], img[6+6*n], img[7+6*n]} <= mk(8'(n));
      send_blk(scbl_pkg::ID_USER_CMD, 16'h000a);
      for (int n = 0; n < 10; n++)
         pop(mk(8'(n)), 1'b1);
      chk(q_rec.size(), 0);
      chk(nid, norm_id);
   endtask : sc_user

   // Bad counts and unknown ids are dropped, normal ids ignored.
   task automatic sc_bad();
      logic [15:0] ids [8] = '{16'h26ad, 16'h26ad, 16'h26ae, 16'h26ae, 16'h26af, 16'h26ac, 16'h0005, 16'hffff};
      logic [15:0] cnts [8] = '{16'h0000, 16'h000b, 16'h0000, 16'h003d, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
      int          d0;
      for (int i = 0; i < 8; i++)
      begin
         d0 = drops;
         send_blk(ids[i], cnts[i]);
         chk(drops - d0, (i < 5) ? 1 : 0);
         chk(q_rec.size(), 0);
      end
   endtask : sc_bad

   // Index list with a disabled entry, an undefined unit and a full count.
   task automatic sc_ctrl();
      cfg(6'h00, mk(8'ha0), 1'b1, 2'h0);
      cfg(6'h05, mk(8'ha5), 1'b0, 2'h1);
      cfg(6'h3f, mk(8'ha3), 1'b1, 2'h1);
      {img[2], img[3], img[4]} <= {16'h0000, 16'h0005, 16'h003f};
      send_blk(scbl_pkg::ID_CMD_CTRL, 16'h0003);
      pop(mk(8'ha0), 1'b1);
      pop(mk(8'ha3), 1'b1);
      chk(q_rec.size(), 0);
      for (int i = 2; i < 62; i++)
         img[i] <= 16'h0000;
      send_blk(scbl_pkg::ID_CMD_CTRL, 16'h003c);
      for (int i = 0; i < 60; i++)
         pop(mk(8'ha0), 1'b1);
   endtask : sc_ctrl

   // Point changes on the cyclic list give step and pulse actions.
   task automatic sc_db();
      logic [15:0] ix [5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0002, 16'h0000};
      logic [15:0] vl [5] = '{16'hffff, 16'h0001, 16'h0000, 16'h0001, 16'h0001};
      logic [2:0]  ac [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
      // Entry one is a step point (type bit zero set), entry two a pulse point.
      cfg(6'h01, {48'h0, 16'h0001, 32'h0}, 1'b1, scbl_pkg::EN_ON_CHANGE);
      cfg(6'h02, {48'h0, 16'h0000, 32'h0}, 1'b1, scbl_pkg::EN_ON_CHANGE);
      for (int i = 0; i < 5; i++)
      begin
         {db_chg, db_idx, db_val} <= {1'b1, ix[i], vl[i]};
         @(posedge clk);
         db_chg <= 1'b0;
         repeat (20) @(posedge clk);
         chk(q_act.size(), (i < 4) ? 1 : 0);
         if (q_act.size() > 0)
         begin
            chk(q_act[0], ac[i]);
            chk(q_hp[0], 1'b0);
            void'(q_rec.pop_front());
            void'(q_hp.pop_front());
            void'(q_act.pop_front());
         end
      end
   endtask : sc_db

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Main sequence after a ten cycle reset.
   initial
   begin
      for (int i = 0; i < scbl_pkg::BLK_WORDS; i++)
         img[i] = 16'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sc_user();
      sc_bad();
      sc_ctrl();
      sc_db();
      final_report();
   end

   // Watchdog cuts a hang well beyond the expected run.
   initial
   begin
      repeat (30000) @(posedge clk);
      mismatches++;
      final_report();
   end
endmodule : special_command_block_loader_test
